// ### design/sls_dir_status.sv
// Lane, channel and error status of one link direction
`timescale 1ns/100ps
module sls_dir_status #(
	parameter int LANES = sls_pkg::LANES
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              core_rst,
	input  wire logic [LANES-1:0]  lane_done,
	input  wire sls_pkg::sls_det_s det,
	output logic      [LANES-1:0]  lane_up,
	output sls_pkg::sls_flags_s    flags
);
	logic [LANES-1:0]    lane_up_reg;
	logic [LANES-1:0]    lane_up_next;
	sls_pkg::sls_flags_s flags_reg;
	sls_pkg::sls_flags_s flags_next;

	assign lane_up_next          = core_rst ? '0 : lane_done;
	assign flags_next.hard_err   = ~core_rst & (flags_reg.hard_err | det.hard_det);
	assign flags_next.soft_err   = ~core_rst & det.soft_det;
	// Channel only after all lanes are up and no fatal error
	assign flags_next.channel_up = ~core_rst & det.chan_done & (&lane_up_reg) & ~flags_reg.hard_err;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lane_up_reg <= '0;
			flags_reg   <= '0;
		end else begin
			lane_up_reg <= lane_up_next;
			flags_reg   <= flags_next;
		end
	end

	assign lane_up = lane_up_reg;
	assign flags   = flags_reg;

	chk_chan_needs_lanes: assert property (@(posedge ref_clk) disable iff (rst)
		flags_reg.channel_up |-> $past(&lane_up_reg) && $past(det.chan_done))
		else $error("channel up without all lanes up");
	chk_lane_follows_done: assert property (@(posedge ref_clk) disable iff (rst)
		!core_rst ##1 1'b1 |-> lane_up_reg == $past(lane_done))
		else $error("lane up does not follow lane done");
	chk_soft_one_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		det.soft_det && !core_rst |=> flags_reg.soft_err ##1 (flags_reg.soft_err == $past(det.soft_det && !core_rst)))
		else $error("soft error not a single cycle pulse");
	chk_hard_held: assert property (@(posedge ref_clk) disable iff (rst)
		flags_reg.hard_err && !core_rst |=> flags_reg.hard_err)
		else $error("fatal error dropped before reset");
endmodule

// ### design/sls_status_top.sv
// Link status reporting core with register bus and interrupt
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module sls_status_top #(
	parameter sls_pkg::sls_mode_e MODE  = sls_pkg::MODE_DUPLEX,
	parameter int                 LANES = sls_pkg::LANES,
	parameter int                 DATA_W = sls_pkg::DATA_W
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic [LANES-1:0]          tx_lane_done,
	input  wire logic [LANES-1:0]          rx_lane_done,
	input  wire sls_pkg::sls_det_s         tx_det,
	input  wire sls_pkg::sls_det_s         rx_det,
	input  wire logic                      tx_clk_stable,
	input  wire logic [LANES-1:0]          tx_serial_in,
	input  wire logic [DATA_W-1:0]         rx_data_in,
	input  wire logic                      rx_valid_in,
	output logic [LANES-1:0]               tx_serial_out,
	output logic [DATA_W-1:0]              rx_user_data,
	output logic                           rx_user_valid,
	output sls_pkg::sls_flags_s            flags,
	output logic [LANES-1:0]               lane_up,
	output sls_pkg::sls_flags_s            tx_flags,
	output logic [LANES-1:0]               tx_lane_up,
	output sls_pkg::sls_flags_s            rx_flags,
	output logic [LANES-1:0]               rx_lane_up,
	output logic                           transceiver_pll_locked,
	output logic                           shared_pll_reset_output,
	output logic                           irq,
	input  wire logic [sls_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [sls_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready
);
	localparam logic TX_PRESENT = (MODE != sls_pkg::MODE_RX_ONLY);
	localparam logic RX_PRESENT = (MODE != sls_pkg::MODE_TX_ONLY);
	localparam logic DUPLEX     = (MODE == sls_pkg::MODE_DUPLEX);

	// Direction 0 is transmit, 1 is receive
	logic [1:0][LANES-1:0]          dir_lane_done;
	sls_pkg::sls_det_s [1:0]        dir_det;
	logic [1:0][LANES-1:0]          dir_lane_up;
	sls_pkg::sls_flags_s [1:0]      dir_flags;
	logic                           core_rst_reg;

	assign dir_lane_done = {rx_lane_done, tx_lane_done};
	assign dir_det       = {rx_det, tx_det};

	genvar d;
	generate
		for (d = 0; d < 2; d++) begin : g_dir
			sls_dir_status #(.LANES(LANES)) u_dir (
				.ref_clk   (ref_clk),
				.rst       (rst),
				.core_rst  (core_rst_reg),
				.lane_done (dir_lane_done[d]),
				.det       (dir_det[d]),
				.lane_up   (dir_lane_up[d]),
				.flags     (dir_flags[d])
			);
		end
	endgenerate

	// Output presentation per build
	sls_pkg::sls_flags_s flags_reg,    flags_next;
	sls_pkg::sls_flags_s tx_flags_reg, tx_flags_next;
	sls_pkg::sls_flags_s rx_flags_reg, rx_flags_next;
	logic [LANES-1:0]    lane_up_reg,    lane_up_next;
	logic [LANES-1:0]    tx_lane_up_reg, tx_lane_up_next;
	logic [LANES-1:0]    rx_lane_up_reg, rx_lane_up_next;
	logic [LANES-1:0]    tx_serial_reg,  tx_serial_next;
	logic [DATA_W-1:0]   rx_data_reg;
	logic                rx_valid_reg,   rx_valid_next;
	logic                rx_all_up;
	logic                pll_locked_reg;
	logic                pll_rst_reg;

	assign flags_next.channel_up = DUPLEX & dir_flags[0].channel_up & dir_flags[1].channel_up;
	assign flags_next.soft_err   = DUPLEX & (dir_flags[0].soft_err | dir_flags[1].soft_err);
	assign flags_next.hard_err   = DUPLEX & (dir_flags[0].hard_err | dir_flags[1].hard_err);
	assign lane_up_next          = DUPLEX ? (dir_lane_up[0] & dir_lane_up[1]) : '0;
	assign tx_flags_next   = (TX_PRESENT && !DUPLEX) ? dir_flags[0] : '0;
	assign tx_lane_up_next = (TX_PRESENT && !DUPLEX) ? dir_lane_up[0] : '0;
	assign rx_flags_next   = (RX_PRESENT && !DUPLEX) ? dir_flags[1] : '0;
	assign rx_lane_up_next = (RX_PRESENT && !DUPLEX) ? dir_lane_up[1] : '0;
	assign tx_serial_next  = TX_PRESENT ? tx_serial_in : '0;
	assign rx_all_up       = RX_PRESENT & (&dir_lane_up[1]);
	assign rx_valid_next   = rx_valid_in & rx_all_up;

	// Status flops on the single user clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags_reg      <= '0;
			tx_flags_reg   <= '0;
			rx_flags_reg   <= '0;
			lane_up_reg    <= '0;
			tx_lane_up_reg <= '0;
			rx_lane_up_reg <= '0;
			tx_serial_reg  <= '0;
			rx_data_reg    <= '0;
			rx_valid_reg   <= 1'b0;
			pll_locked_reg <= 1'b0;
		end else begin
			flags_reg      <= flags_next;
			tx_flags_reg   <= tx_flags_next;
			rx_flags_reg   <= rx_flags_next;
			lane_up_reg    <= lane_up_next;
			tx_lane_up_reg <= tx_lane_up_next;
			rx_lane_up_reg <= rx_lane_up_next;
			tx_serial_reg  <= tx_serial_next;
			rx_data_reg    <= rx_valid_next ? rx_data_in : rx_data_reg;
			rx_valid_reg   <= rx_valid_next;
			pll_locked_reg <= tx_clk_stable;
		end
	end

	// Partner pll reset asserts with rst, no clock needed, then follows the control pll reset bit
	logic [1:0] ctrl_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pll_rst_reg <= 1'b1;
		end else begin
			pll_rst_reg <= ctrl_reg[sls_pkg::CTRL_PLL_RST_BIT];
		end
	end

	// Register bus slave
	logic                        aw_held_reg, aw_held_next;
	logic                        w_held_reg,  w_held_next;
	logic                        awready_reg, wready_reg;
	logic [sls_pkg::ADDR_W-1:0]  awaddr_reg;
	logic [31:0]                 wdata_reg;
	logic                        wstrb0_reg;
	logic                        bvalid_reg,  bvalid_next;
	logic [1:0]                  bresp_reg;
	logic                        arready_reg, rvalid_reg, rvalid_next;
	logic [31:0]                 rdata_reg,   rdata_next;
	logic [1:0]                  rresp_reg,   rresp_next;
	logic                        aw_take, w_take, wr_do, ar_take;
	logic                        wr_ctrl, wr_stat, wr_mask, wr_mapped;
	logic [sls_pkg::EV_W-1:0]    irq_stat_reg, irq_stat_next, irq_mask_reg, events, w1c;
	logic [31:0]                 status_word;
	logic                        irq_reg;
	logic                        chan_up_any, chan_up_prev_reg;

	assign aw_take      = s_axi_awvalid & awready_reg;
	assign w_take       = s_axi_wvalid & wready_reg;
	assign wr_do        = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign aw_held_next = (aw_held_reg & ~wr_do) | aw_take;
	assign w_held_next  = (w_held_reg & ~wr_do) | w_take;
	assign bvalid_next  = wr_do | (bvalid_reg & ~s_axi_bready);
	assign wr_ctrl      = wr_do & wstrb0_reg & (awaddr_reg == sls_pkg::ADDR_CTRL);
	assign wr_stat      = wr_do & wstrb0_reg & (awaddr_reg == sls_pkg::ADDR_IRQ_STAT);
	assign wr_mask      = wr_do & wstrb0_reg & (awaddr_reg == sls_pkg::ADDR_IRQ_MASK);
	assign wr_mapped    = (awaddr_reg == sls_pkg::ADDR_CTRL) | (awaddr_reg == sls_pkg::ADDR_STATUS)
		| (awaddr_reg == sls_pkg::ADDR_IRQ_STAT) | (awaddr_reg == sls_pkg::ADDR_IRQ_MASK)
		| (awaddr_reg == sls_pkg::ADDR_CONFIG);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb0_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= sls_pkg::RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			awready_reg <= ~aw_held_next;
			wready_reg  <= ~w_held_next;
			awaddr_reg  <= aw_take ? s_axi_awaddr : awaddr_reg;
			wdata_reg   <= w_take ? s_axi_wdata : wdata_reg;
			wstrb0_reg  <= w_take ? s_axi_wstrb[0] : wstrb0_reg;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= wr_do ? (wr_mapped ? sls_pkg::RESP_OKAY : sls_pkg::RESP_SLVERR) : bresp_reg;
		end
	end

	// Control and interrupt registers; a set beats a same-cycle clear
	assign chan_up_any   = DUPLEX ? flags_reg.channel_up : (tx_flags_reg.channel_up | rx_flags_reg.channel_up);
	assign events[sls_pkg::EV_TX_SOFT]   = dir_flags[0].soft_err & TX_PRESENT;
	assign events[sls_pkg::EV_RX_SOFT]   = dir_flags[1].soft_err & RX_PRESENT;
	assign events[sls_pkg::EV_TX_HARD]   = dir_flags[0].hard_err & TX_PRESENT;
	assign events[sls_pkg::EV_RX_HARD]   = dir_flags[1].hard_err & RX_PRESENT;
	assign events[sls_pkg::EV_CHAN_DOWN] = chan_up_prev_reg & ~chan_up_any;
	assign events[sls_pkg::EV_LOCK_LOSS] = pll_locked_reg & ~tx_clk_stable;
	assign w1c           = wr_stat ? wdata_reg[sls_pkg::EV_W-1:0] : '0;
	assign irq_stat_next = (irq_stat_reg & ~w1c) | events;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg         <= sls_pkg::CTRL_RESET;
			core_rst_reg     <= 1'b0;
			irq_mask_reg     <= sls_pkg::MASK_RESET;
			irq_stat_reg     <= '0;
			irq_reg          <= 1'b0;
			chan_up_prev_reg <= 1'b0;
		end else begin
			ctrl_reg         <= wr_ctrl ? {1'b0, wdata_reg[sls_pkg::CTRL_PLL_RST_BIT]} : ctrl_reg;
			core_rst_reg     <= wr_ctrl & wdata_reg[sls_pkg::CTRL_CORE_RST_BIT];
			irq_mask_reg     <= wr_mask ? wdata_reg[sls_pkg::EV_W-1:0] : irq_mask_reg;
			irq_stat_reg     <= irq_stat_next;
			irq_reg          <= |(irq_stat_next & irq_mask_reg);
			chan_up_prev_reg <= chan_up_any;
		end
	end

	// Read side
	assign status_word = {10'h000,
		chan_up_any, pll_locked_reg,
		dir_flags[1].hard_err, dir_flags[0].hard_err,
		dir_flags[1].channel_up, dir_flags[0].channel_up,
		8'(dir_lane_up[1]), 8'(dir_lane_up[0])};
	assign ar_take     = s_axi_arvalid & arready_reg;
	assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

	always_comb begin
		rdata_next = '0;
		rresp_next = sls_pkg::RESP_OKAY;
		case (s_axi_araddr)
			sls_pkg::ADDR_CTRL:     rdata_next = {30'h00000000, ctrl_reg};
			sls_pkg::ADDR_STATUS:   rdata_next = status_word;
			sls_pkg::ADDR_IRQ_STAT: rdata_next = {26'h0000000, irq_stat_reg};
			sls_pkg::ADDR_IRQ_MASK: rdata_next = {26'h0000000, irq_mask_reg};
			sls_pkg::ADDR_CONFIG:   rdata_next = {16'h0000, 8'(LANES), 6'h00, MODE};
			default:                rresp_next = sls_pkg::RESP_SLVERR;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= sls_pkg::RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= ar_take ? rdata_next : rdata_reg;
			rresp_reg   <= ar_take ? rresp_next : rresp_reg;
		end
	end

	assign tx_serial_out           = tx_serial_reg;
	assign rx_user_data            = rx_data_reg;
	assign rx_user_valid           = rx_valid_reg;
	assign flags                   = flags_reg;
	assign lane_up                 = lane_up_reg;
	assign tx_flags                = tx_flags_reg;
	assign tx_lane_up              = tx_lane_up_reg;
	assign rx_flags                = rx_flags_reg;
	assign rx_lane_up              = rx_lane_up_reg;
	assign transceiver_pll_locked  = pll_locked_reg;
	assign shared_pll_reset_output = pll_rst_reg;
	assign irq                     = irq_reg;
	assign s_axi_awready           = awready_reg;
	assign s_axi_wready            = wready_reg;
	assign s_axi_bvalid            = bvalid_reg;
	assign s_axi_bresp             = bresp_reg;
	assign s_axi_arready           = arready_reg;
	assign s_axi_rvalid            = rvalid_reg;
	assign s_axi_rdata             = rdata_reg;
	assign s_axi_rresp             = rresp_reg;

	chk_rx_gate_lanes: assert property (@(posedge ref_clk) disable iff (rst)
		rx_valid_reg |-> $past(&dir_lane_up[1]) && $past(rx_valid_in))
		else $error("rx data accepted before all lanes up");
	chk_soft_out_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		DUPLEX && tx_det.soft_det && !core_rst_reg |-> ##2 flags_reg.soft_err)
		else $error("combined soft error pulse missing");
	chk_pll_follows: assert property (@(posedge ref_clk) disable iff (rst)
		tx_clk_stable != pll_locked_reg |=> pll_locked_reg == $past(tx_clk_stable))
		else $error("pll locked does not follow clock stable");
	chk_duplex_combined: assert property (@(posedge ref_clk) disable iff (rst)
		flags_reg.channel_up |-> DUPLEX && $past(dir_flags[0].channel_up) && $past(dir_flags[1].channel_up))
		else $error("combined channel up without both sides");
	chk_tx_side_view: assert property (@(posedge ref_clk) disable iff (rst)
		##1 tx_flags_reg == ((TX_PRESENT && !DUPLEX) ? $past(dir_flags[0]) : 3'h0))
		else $error("transmit side flags wrong for build");
	chk_rx_side_view: assert property (@(posedge ref_clk) disable iff (rst)
		##1 rx_flags_reg == ((RX_PRESENT && !DUPLEX) ? $past(dir_flags[1]) : 3'h0))
		else $error("receive side flags wrong for build");
	chk_tx_pins_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		!TX_PRESENT |-> tx_serial_reg == '0)
		else $error("serial transmit pins driven in receive-only build");
	chk_pll_reset_ctrl: assert property (@(posedge ref_clk) disable iff (rst)
		wr_ctrl |-> ##2 pll_rst_reg == $past(wdata_reg[sls_pkg::CTRL_PLL_RST_BIT], 2))
		else $error("shared pll reset does not follow control");
	chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
		irq_reg |-> $past(|(irq_stat_next & irq_mask_reg)))
		else $error("interrupt without unmasked status");
	chk_hard_out_held: assert property (@(posedge ref_clk) disable iff (rst)
		flags_reg.hard_err && !core_rst_reg && !$past(core_rst_reg) |=> flags_reg.hard_err)
		else $error("combined fatal error dropped before reset");
	chk_soft_out_source: assert property (@(posedge ref_clk) disable iff (rst)
		flags_reg.soft_err |-> $past(dir_flags[0].soft_err || dir_flags[1].soft_err))
		else $error("combined soft error without a detected error");
	chk_lane_combined: assert property (@(posedge ref_clk) disable iff (rst)
		##1 lane_up_reg == (DUPLEX ? $past(dir_lane_up[0] & dir_lane_up[1]) : '0))
		else $error("combined lane ready wrong for build");
	chk_serial_follows: assert property (@(posedge ref_clk) disable iff (rst)
		TX_PRESENT |=> tx_serial_reg == $past(tx_serial_in))
		else $error("serial transmit pins do not follow lane data");
	chk_bvalid_held: assert property (@(posedge ref_clk) disable iff (rst)
		bvalid_reg && !s_axi_bready |=> bvalid_reg && $stable(bresp_reg))
		else $error("write response withdrawn before taken");
	chk_rvalid_held: assert property (@(posedge ref_clk) disable iff (rst)
		rvalid_reg && !s_axi_rready |=> rvalid_reg && $stable(rdata_reg) && $stable(rresp_reg))
		else $error("read response withdrawn before taken");
	chk_event_sets_stat: assert property (@(posedge ref_clk) disable iff (rst)
		|events |=> (irq_stat_reg & $past(events)) == $past(events))
		else $error("status bit lost on a same-cycle clear");
endmodule

// ### inc/sls_pkg.sv
// Constants and carrier types for the serial link status block
package sls_pkg;
	localparam int LANES   = 4;
	localparam int DATA_W  = 64;
	localparam int ADDR_W  = 8;

	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_CONFIG   = 8'h10;

	localparam int CTRL_PLL_RST_BIT  = 0;
	localparam int CTRL_CORE_RST_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	localparam int EV_TX_SOFT   = 0;
	localparam int EV_RX_SOFT   = 1;
	localparam int EV_TX_HARD   = 2;
	localparam int EV_RX_HARD   = 3;
	localparam int EV_CHAN_DOWN = 4;
	localparam int EV_LOCK_LOSS = 5;
	localparam int EV_W         = 6;
	localparam logic [5:0] MASK_RESET = 6'h00;

	localparam int STAT_RX_LANE_LSB = 8;
	localparam int STAT_TX_CHAN     = 16;
	localparam int STAT_RX_CHAN     = 17;
	localparam int STAT_TX_HARD     = 18;
	localparam int STAT_RX_HARD     = 19;
	localparam int STAT_PLL_LOCK    = 20;
	localparam int STAT_CHAN_UP     = 21;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_DUPLEX, MODE_TX_ONLY, MODE_RX_ONLY, MODE_SPLIT} sls_mode_e;

	typedef struct packed {
		logic chan_done;
		logic soft_det;
		logic hard_det;
	} sls_det_s;

	typedef struct packed {
		logic channel_up;
		logic soft_err;
		logic hard_err;
	} sls_flags_s;
endpackage

// ### tb/serial_link_status_reporting_bench.sv
// Self-checking bench for the link status core
`timescale 1ns/100ps
module serial_link_status_reporting_bench;
	logic ref_clk, rst, run, app_rst;
	logic [3:0] tx_lane_done, rx_lane_done, tx_serial_in, tx_serial_out, lane_up, tx_lane_up, rx_lane_up, s_axi_wstrb;
	sls_pkg::sls_det_s tx_det, rx_det;
	sls_pkg::sls_flags_s flags, tx_flags, rx_flags;
	logic [63:0] rx_data_in, rx_user_data, rx_d1;
	sls_pkg::sls_flags_s sp_flags, sp_tx_flags, sp_rx_flags;
	logic [3:0] sp_lane_up, sp_tx_lane_up, sp_rx_lane_up;
	logic [16:0] sp_view;
	logic tx_clk_stable, rx_valid_in, rx_user_valid, transceiver_pll_locked, shared_pll_reset_output, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] d1;
	int miscompares, samples_checked, soft_count, rx_count, s0;

	sls_status_top i_dut (.ref_clk, .rst, .tx_lane_done, .rx_lane_done, .tx_det, .rx_det, .tx_clk_stable,
		.tx_serial_in, .rx_data_in, .rx_valid_in, .tx_serial_out, .rx_user_data, .rx_user_valid, .flags,
		.lane_up, .tx_flags, .tx_lane_up, .rx_flags, .rx_lane_up, .transceiver_pll_locked,
		.shared_pll_reset_output, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	sls_user_app i_app (.ref_clk, .transceiver_pll_locked, .flags, .rx_user_valid, .app_rst, .soft_count,
		.rx_count);

	// Split build on the same stimulus, for the per-direction views
	sls_status_top #(.MODE(sls_pkg::MODE_SPLIT)) i_dut_split (.ref_clk, .rst, .tx_lane_done, .rx_lane_done,
		.tx_det, .rx_det, .tx_clk_stable, .tx_serial_in, .rx_data_in, .rx_valid_in, .tx_serial_out(),
		.rx_user_data(), .rx_user_valid(), .flags(sp_flags), .lane_up(sp_lane_up), .tx_flags(sp_tx_flags),
		.tx_lane_up(sp_tx_lane_up), .rx_flags(sp_rx_flags), .rx_lane_up(sp_rx_lane_up),
		.transceiver_pll_locked(), .shared_pll_reset_output(), .irq(), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);

	assign sp_view = {sp_tx_flags.channel_up, sp_rx_flags.channel_up, sp_tx_lane_up, sp_rx_lane_up, sp_flags, sp_lane_up};

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 100) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				s_axi_bready <= 1'b0;
				chk("bresp", s_axi_bresp, sls_pkg::RESP_OKAY);
				n = 200;
			end
		end
		if (n < 200)
			chk("write answer", 0, 1);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 100) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				s_axi_rready <= 1'b0;
				chk("rresp", s_axi_rresp, er);
				d = s_axi_rdata;
				n = 200;
			end
		end
		if (n < 200)
			chk("read answer", 0, 1);
	endtask

	initial begin
		ref_clk = 0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Random serial and lock stimulus, checked against a one-edge copy
	always @(posedge ref_clk) begin
		seed = xs(seed);
		tx_serial_in <= seed[3:0];
		tx_clk_stable <= seed[8] | seed[9];
		rx_data_in <= {seed, ~seed};
		d1 <= {tx_clk_stable, tx_serial_in};
		rx_d1 <= rx_data_in;
		if (run) begin
			chk("pll_locked", transceiver_pll_locked, d1[4]);
			chk("serial_out", tx_serial_out, d1[3:0]);
			chk("side_flags", {tx_flags, rx_flags, tx_lane_up, rx_lane_up}, 0);
			if (rx_user_valid === 1'b1) begin
				chk("rx_data_hi", rx_user_data[63:32], rx_d1[63:32]);
				chk("rx_data_lo", rx_user_data[31:0], rx_d1[31:0]);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		wrap_up();
	end

	initial begin
		{rst, run, seed, miscompares, samples_checked} = {2'b10, 32'h113ae145, 64'h0};
		{tx_lane_done, rx_lane_done, tx_det, rx_det, rx_valid_in, tx_clk_stable} = 0;
		{tx_serial_in, rx_data_in, d1} = 0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		run <= 1'b1;
		chk("shared_rst", shared_pll_reset_output, 0);
		axi_rd(sls_pkg::ADDR_IRQ_MASK, sls_pkg::RESP_OKAY, rd);
		chk("mask reset", rd, 32'h0);
		axi_rd(sls_pkg::ADDR_CONFIG, sls_pkg::RESP_OKAY, rd);
		chk("config", rd, 32'h0000_0400);
		axi_rd(8'h20, sls_pkg::RESP_SLVERR, rd);
		chk("unmapped", rd, 32'h0);
		// Three of four lanes: no channel and no received data
		{tx_lane_done, rx_lane_done} <= 8'h77;
		tx_det.chan_done <= 1'b1;
		rx_det.chan_done <= 1'b1;
		rx_valid_in <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("lane_up", lane_up, 4'h7);
		chk("channel_up", flags.channel_up, 0);
		chk("rx_valid", rx_user_valid, 0);
		chk("split view", sp_view, {2'h0, 8'h77, 7'h00});
		{tx_lane_done, rx_lane_done} <= 8'hff;
		repeat (6) @(posedge ref_clk);
		chk("lane_up", lane_up, 4'hf);
		chk("channel_up", flags.channel_up, 1);
		chk("rx_valid", rx_user_valid, 1);
		chk("split view", sp_view, {2'h3, 8'hff, 7'h00});
		s0 = soft_count;
		tx_det.soft_det <= 1'b1;
		@(posedge ref_clk);
		tx_det.soft_det <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("soft pulses", soft_count - s0, 1);
		chk("irq masked", irq, 0);
		axi_rd(sls_pkg::ADDR_IRQ_STAT, sls_pkg::RESP_OKAY, rd);
		chk("soft event", rd[sls_pkg::EV_TX_SOFT], 1);
		axi_wr(sls_pkg::ADDR_IRQ_MASK, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("irq on", irq, 1);
		axi_wr(sls_pkg::ADDR_IRQ_STAT, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("irq cleared", irq, 0);
		// Fatal error holds until a core reset
		rx_det.hard_det <= 1'b1;
		@(posedge ref_clk);
		rx_det.hard_det <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("hard held", flags.hard_err, 1);
		chk("chan dropped", flags.channel_up, 0);
		chk("split hard", {sp_tx_flags.hard_err, sp_rx_flags.hard_err}, 2'h1);
		axi_wr(sls_pkg::ADDR_CTRL, 32'h2);
		repeat (4) @(posedge ref_clk);
		chk("hard cleared", flags.hard_err, 0);
		axi_wr(sls_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("shared_rst on", shared_pll_reset_output, 1);
		axi_wr(sls_pkg::ADDR_CTRL, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("shared_rst off", shared_pll_reset_output, 0);
		chk("rx beats seen", rx_count > 0, 1);
		wrap_up();
	end
endmodule

// ### tb/sls_user_app.sv
// User application model that consumes the link status outputs
`timescale 1ns/100ps
module sls_user_app (
	input  wire logic                ref_clk,
	input  wire logic                transceiver_pll_locked,
	input  wire sls_pkg::sls_flags_s flags,
	input  wire logic                rx_user_valid,
	output logic                     app_rst,
	output int                       soft_count,
	output int                       rx_count
);
	int tx_beats;

	// Transmit clock logic stays in reset until the pll reports lock
	assign app_rst = transceiver_pll_locked !== 1'b1;

	initial begin
		soft_count = 0;
		rx_count = 0;
		tx_beats = 0;
	end

	always @(posedge ref_clk) begin
		tx_beats <= app_rst ? 0 : tx_beats + 1;
		if (flags.soft_err === 1'b1)
			soft_count <= soft_count + 1;
		if (rx_user_valid === 1'b1)
			rx_count <= rx_count + 1;
	end
endmodule
